// ===== src/pief_pkg.sv
// Constants for the peripheral interrupt enable and flag register block
package pief_pkg;
    // Register byte offsets on the APB bus
    localparam logic [7:0] PIEF_EN6_OFS = 8'h00;
    localparam logic [7:0] PIEF_REQ_OFS = 8'h04;
    localparam logic [7:0] PIEF_CTRL_OFS = 8'h08;
    localparam logic [7:0] PIEF_STAT_OFS = 8'h0c;
    localparam logic [7:0] PIEF_MASK_OFS = 8'h10;
    localparam logic [7:0] PIEF_PSEL_OFS = 8'h14;

    // Enable register fields
    localparam int PIEF_MEM_EN_BIT = 5;
    localparam int PIEF_OSC_EN_BIT = 4;
    localparam int PIEF_WAVE_EN_BIT = 0;
    localparam logic [7:0] PIEF_EN6_MASK = 8'h31;

    // Request register fields
    localparam int PIEF_TMR_FLAG_BIT = 5;
    localparam int PIEF_PCHG_FLAG_BIT = 4;
    localparam int PIEF_EXT_FLAG_BIT = 0;

    // Control register fields
    localparam int PIEF_GLOBAL_EN_BIT = 7;
    localparam int PIEF_PERIPH_EN_BIT = 6;
    localparam logic [7:0] PIEF_CTRL_MASK = 8'hc0;

    // Event status and mask layout
    localparam int PIEF_EV_NUM = 4;
    localparam int PIEF_EV_TMR = 0;
    localparam int PIEF_EV_EXT = 1;
    localparam int PIEF_EV_PCHG = 2;
    localparam int PIEF_EV_FWD = 3;

    // Pin select and port widths
    localparam int PIEF_PIN_NUM = 8;
    localparam int PIEF_PSEL_W = 3;
    localparam int PIEF_PORT_A_W = 6;
    localparam int PIEF_PORT_E_W = 1;

    // Reset values
    localparam logic [7:0] PIEF_EN6_RST = 8'h00;
    localparam logic [7:0] PIEF_CTRL_RST = 8'h00;
    localparam logic [3:0] PIEF_MASK_RST = 4'h0;
    localparam logic [2:0] PIEF_PSEL_RST = 3'h0;
endpackage

// ===== src/pief_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pief_sync (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Asynchronous pin and filtered level
    input wire logic pin,
    output logic level
);
    logic s1_q, s2_q, s3_q, lvl_q;
    logic lvl_d;

    ////////////////////////////////////////////////////////////////////////////////
    // Level follows only when stages two and three agree
    always_comb begin
        lvl_d = lvl_q;
        if (s2_q == s3_q) begin
            lvl_d = s3_q;
        end
    end

    // First stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            lvl_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign level = lvl_q;
endmodule // pief_sync

// ===== src/pief_flag_bit.sv
// One sticky flag bit, hardware set wins over software write
`timescale 1ns/1ps
module pief_flag_bit (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Hardware set and software write
    input wire logic set,
    input wire logic wr_en,
    input wire logic wr_val,
    // Flag state
    output logic flag
);
    logic flag_q, flag_d;

    ////////////////////////////////////////////////////////////////////////////////
    // Set has priority so a same-cycle event is never lost
    always_comb begin
        flag_d = flag_q;
        if (set) begin
            flag_d = 1'b1;
        end else if (wr_en) begin
            flag_d = wr_val;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag = flag_q;
endmodule // pief_flag_bit

// ===== src/pief_regs.sv
// Peripheral interrupt enable and request flag registers with APB access
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module pief_regs
    import pief_pkg::*;
(
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Events from peripherals on this clock
    input wire logic timer_overflow,
    input wire logic [PIEF_PORT_A_W-1:0] port_a_change_flags,
    input wire logic [PIEF_PORT_E_W-1:0] port_e_change_flags,
    // Flags held in the peripheral request registers outside
    input wire logic mem_task_flag,
    input wire logic osc_rollover_flag,
    input wire logic waveform_gen_flag,
    // Asynchronous external interrupt pins
    input wire logic [PIEF_PIN_NUM-1:0] ext_pins,
    // Flag and request outputs
    output logic timer_overflow_flag,
    output logic pin_change_summary_flag,
    output logic ext_pin_irq_flag,
    output logic periph_irq_request,
    output logic irq
);
    // Register state
    logic [7:0] en6_q, en6_d;
    logic [7:0] ctrl_q, ctrl_d;
    logic [PIEF_EV_NUM-1:0] mask_q, mask_d;
    logic [PIEF_PSEL_W-1:0] psel_q, psel_d;
    // Bus answer state
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;
    // Pin path state
    logic [PIEF_PIN_NUM-1:0] pin_lvl;
    logic ext_lvl_q, ext_lvl_d;
    logic sel_chg_q, sel_chg_d;
    // Derived request state
    logic pchg_q, pchg_d;
    logic fwd_q, fwd_d;
    logic irq_q, irq_d;
    // Flags
    logic tmr_flag, ext_flag;
    logic [PIEF_EV_NUM-1:0] stat;
    // Combinational helpers
    logic wr_acc, rd_acc, hit;
    logic ext_rise, pchg_now, fwd_now;
    logic [7:0] req_view;
    logic [PIEF_EV_NUM-1:0] ev_set;
    logic [31:0] rd_val;

    ////////////////////////////////////////////////////////////////////////////////
    // APB access phase; pready rises one cycle into access, so every
    // transfer takes exactly one wait state
    always_comb begin
        pready_d = psel & penable & ~pready_q;
    end

    // Write commits only at the edge that also samples pready high
    assign wr_acc = psel & penable & pready_q & pwrite;
    assign rd_acc = psel & penable & ~pready_q & ~pwrite;

    // Address decode and read mux
    always_comb begin
        hit = 1'b1;
        rd_val = 32'h0000_0000;
        if (paddr == PIEF_EN6_OFS) begin
            rd_val = {24'h00_0000, en6_q & PIEF_EN6_MASK};
        end else if (paddr == PIEF_REQ_OFS) begin
            rd_val = {24'h00_0000, req_view};
        end else if (paddr == PIEF_CTRL_OFS) begin
            rd_val = {24'h00_0000, ctrl_q & PIEF_CTRL_MASK};
        end else if (paddr == PIEF_STAT_OFS) begin
            rd_val = {28'h000_0000, stat};
        end else if (paddr == PIEF_MASK_OFS) begin
            rd_val = {28'h000_0000, mask_q};
        end else if (paddr == PIEF_PSEL_OFS) begin
            rd_val = {29'h0000_0000, psel_q};
        end else begin
            hit = 1'b0;
        end
    end

    // Read data and error are loaded together with pready
    always_comb begin
        prdata_d = prdata_q;
        pslverr_d = 1'b0;
        if (pready_d) begin
            pslverr_d = ~hit;
            prdata_d = rd_acc ? rd_val : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Writable configuration registers; unimplemented bits never stored
    always_comb begin
        en6_d = en6_q;
        ctrl_d = ctrl_q;
        mask_d = mask_q;
        psel_d = psel_q;
        if (wr_acc) begin
            if (paddr == PIEF_EN6_OFS) begin
                en6_d = pwdata[7:0] & PIEF_EN6_MASK;
            end else if (paddr == PIEF_CTRL_OFS) begin
                ctrl_d = pwdata[7:0] & PIEF_CTRL_MASK;
            end else if (paddr == PIEF_MASK_OFS) begin
                mask_d = pwdata[PIEF_EV_NUM-1:0];
            end else if (paddr == PIEF_PSEL_OFS) begin
                psel_d = pwdata[PIEF_PSEL_W-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en6_q <= PIEF_EN6_RST;
            ctrl_q <= PIEF_CTRL_RST;
            mask_q <= PIEF_MASK_RST;
            psel_q <= PIEF_PSEL_RST;
        end else begin
            en6_q <= en6_d;
            ctrl_q <= ctrl_d;
            mask_q <= mask_d;
            psel_q <= psel_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Every pin is synchronised so a reselect sees a settled level
    genvar gi;
    generate
        for (gi = 0; gi < PIEF_PIN_NUM; gi++) begin : g_pin
            pief_sync u_sync (
                .pclk(pclk),
                .presetn(presetn),
                .pin(ext_pins[gi]),
                .level(pin_lvl[gi])
            );
        end
    endgenerate

    // Selected pin level; a select change masks one edge, since
    // swapping pins is not an interrupt on the new pin
    always_comb begin
        ext_lvl_d = pin_lvl[psel_q];
        sel_chg_d = (psel_d != psel_q);
    end

    assign ext_rise = ext_lvl_d & ~ext_lvl_q & ~sel_chg_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_lvl_q <= 1'b0;
            sel_chg_q <= 1'b0;
        end else begin
            ext_lvl_q <= ext_lvl_d;
            sel_chg_q <= sel_chg_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Request flags: hardware set ignores every enable, software
    // write of the register bit stores it
    pief_flag_bit u_tmr_flag (
        .pclk(pclk),
        .presetn(presetn),
        .set(timer_overflow),
        .wr_en(wr_acc && paddr == PIEF_REQ_OFS),
        .wr_val(pwdata[PIEF_TMR_FLAG_BIT]),
        .flag(tmr_flag)
    );

    pief_flag_bit u_ext_flag (
        .pclk(pclk),
        .presetn(presetn),
        .set(ext_rise),
        .wr_en(wr_acc && paddr == PIEF_REQ_OFS),
        .wr_val(pwdata[PIEF_EXT_FLAG_BIT]),
        .flag(ext_flag)
    );

    // Summary flag has no storage; it drops only when every port bit is clear
    assign pchg_now = |port_a_change_flags | |port_e_change_flags;

    // Request register view, unimplemented bits read zero
    always_comb begin
        req_view = 8'h00;
        req_view[PIEF_TMR_FLAG_BIT] = tmr_flag;
        req_view[PIEF_PCHG_FLAG_BIT] = pchg_now;
        req_view[PIEF_EXT_FLAG_BIT] = ext_flag;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Forwarded peripheral request needs both control enables;
    // stale flags fire at once if enabled first, so clear them before
    // setting an enable
    always_comb begin
        fwd_now = ctrl_q[PIEF_GLOBAL_EN_BIT] & ctrl_q[PIEF_PERIPH_EN_BIT] &
                  ((en6_q[PIEF_MEM_EN_BIT] & mem_task_flag) |
                   (en6_q[PIEF_OSC_EN_BIT] & osc_rollover_flag) |
                   (en6_q[PIEF_WAVE_EN_BIT] & waveform_gen_flag));
        pchg_d = pchg_now;
        fwd_d = fwd_now;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pchg_q <= 1'b0;
            fwd_q <= 1'b0;
        end else begin
            pchg_q <= pchg_d;
            fwd_q <= fwd_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Event status: sticky, write one to clear, set beats clear
    always_comb begin
        ev_set = '0;
        ev_set[PIEF_EV_TMR] = timer_overflow;
        ev_set[PIEF_EV_EXT] = ext_rise;
        ev_set[PIEF_EV_PCHG] = pchg_now & ~pchg_q;
        ev_set[PIEF_EV_FWD] = fwd_now & ~fwd_q;
    end

    generate
        for (gi = 0; gi < PIEF_EV_NUM; gi++) begin : g_stat
            pief_flag_bit u_stat (
                .pclk(pclk),
                .presetn(presetn),
                .set(ev_set[gi]),
                .wr_en(wr_acc && paddr == PIEF_STAT_OFS && pwdata[gi]),
                .wr_val(1'b0),
                .flag(stat[gi])
            );
        end
    endgenerate

    // Interrupt line is a registered level of unmasked status
    always_comb begin
        irq_d = |(stat & mask_q);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs, all from flip-flops
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign timer_overflow_flag = tmr_flag;
    assign ext_pin_irq_flag = ext_flag;
    assign pin_change_summary_flag = pchg_q;
    assign periph_irq_request = fwd_q;
    assign irq = irq_q;
endmodule // pief_regs

// ===== tb/pief_regs_asserts.sv
// Port-level checker for the interrupt enable and flag register block
`timescale 1ns/1ps
module pief_regs_asserts
    import pief_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Events and flags
    input wire logic timer_overflow,
    input wire logic [PIEF_PORT_A_W-1:0] port_a_change_flags,
    input wire logic [PIEF_PORT_E_W-1:0] port_e_change_flags,
    input wire logic mem_task_flag,
    input wire logic osc_rollover_flag,
    input wire logic waveform_gen_flag,
    input wire logic [PIEF_PIN_NUM-1:0] ext_pins,
    input wire logic timer_overflow_flag,
    input wire logic pin_change_summary_flag,
    input wire logic ext_pin_irq_flag,
    input wire logic periph_irq_request,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////
    // Completed write to the request register, seen at its pready edge
    logic req_wr;
    assign req_wr = psel && penable && pready && pwrite && (paddr == PIEF_REQ_OFS);
    ////////////////////////////////////////////////////////////////////////////
    chk_one_wait: assert property (psel && !penable |=> !pready ##1 pready) else $error("pready timing off");
    chk_ready_pulse: assert property (pready |=> !pready) else $error("pready held high");
    chk_err_data: assert property (pslverr |-> pready && prdata == 32'h0) else $error("error with data");
    chk_read_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper bits set");
    chk_tmr_set: assert property (timer_overflow |=> timer_overflow_flag) else $error("timer flag missed");
    chk_tmr_hold: assert property ($fell(timer_overflow_flag) |-> $past(req_wr && !pwdata[PIEF_TMR_FLAG_BIT]))
        else $error("timer flag lost");
    chk_ext_hold: assert property ($fell(ext_pin_irq_flag) |-> $past(req_wr && !pwdata[PIEF_EXT_FLAG_BIT]))
        else $error("pin flag lost");
    chk_summary_or: assert property ($past(presetn) |->
        pin_change_summary_flag == $past(|{port_a_change_flags, port_e_change_flags}))
        else $error("summary not the OR");
    chk_fwd_cause: assert property (periph_irq_request |->
        $past(mem_task_flag | osc_rollover_flag | waveform_gen_flag)) else $error("request without flag");
    // Main scenarios reached
    cov_error: cover property (pslverr);
    cov_timer: cover property (timer_overflow ##1 timer_overflow_flag);
    cov_irq: cover property ($rose(irq));
    cov_fwd: cover property ($rose(periph_irq_request));
endmodule // pief_regs_asserts

bind pief_regs pief_regs_asserts u_pief_regs_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_overflow(timer_overflow), .port_a_change_flags(port_a_change_flags),
    .port_e_change_flags(port_e_change_flags), .mem_task_flag(mem_task_flag),
    .osc_rollover_flag(osc_rollover_flag), .waveform_gen_flag(waveform_gen_flag), .ext_pins(ext_pins),
    .timer_overflow_flag(timer_overflow_flag), .pin_change_summary_flag(pin_change_summary_flag),
    .ext_pin_irq_flag(ext_pin_irq_flag), .periph_irq_request(periph_irq_request), .irq(irq));

// ===== tb/tb_pief_regs.sv
// Self-checking bench for the interrupt enable and flag register block
`timescale 1ns/1ps
module tb_pief_regs
    import pief_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, timer_overflow = 1'b0, mem_f = 1'b0, osc_f = 1'b0, wave_f = 1'b0;
    logic [PIEF_PORT_A_W-1:0] pa = '0;
    logic [PIEF_PORT_E_W-1:0] pe = '0;
    logic [PIEF_PIN_NUM-1:0] pins = '0;
    logic tmr_flag, pchg_flag, ext_flag, fwd, irq;
    int fail_count = 0, tests_run = 0;

    pief_regs u_pief_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_overflow(timer_overflow), .port_a_change_flags(pa), .port_e_change_flags(pe),
        .mem_task_flag(mem_f), .osc_rollover_flag(osc_f), .waveform_gen_flag(wave_f), .ext_pins(pins),
        .timer_overflow_flag(tmr_flag), .pin_change_summary_flag(pchg_flag), .ext_pin_irq_flag(ext_flag),
        .periph_irq_request(fwd), .irq(irq));

    // 100 ns clock
    initial begin
        forever #50 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task end_sim;
        if (fail_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Compare a word and a single flag
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task chk1(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    // One APB transfer; waits for pready under a bound, never a fixed count
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            fail_count++;
            $display("wrong value at %0t: pready never came", $time);
            end_sim();
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, {24'h0, d}, r, e);
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
        chk1(e, exp_err);
    endtask
    task settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Reset values, unmapped address refused
    task t_reset;
        rd_chk(PIEF_EN6_OFS, 32'h0, 1'b0);
        rd_chk(PIEF_REQ_OFS, 32'h0, 1'b0);
        rd_chk(8'h18, 32'h0, 1'b1);
    endtask
    // Only bits 5, 4 and 0 of the enable register hold
    task t_enable;
        wr(PIEF_EN6_OFS, 8'hff);
        rd_chk(PIEF_EN6_OFS, 32'h31, 1'b0);
        wr(PIEF_EN6_OFS, 8'h00);
        rd_chk(PIEF_EN6_OFS, 32'h0, 1'b0);
    endtask
    // Timer flag sets with all enables off, stays until written to 0
    task t_timer;
        wr(PIEF_STAT_OFS, 8'h0f);
        wr(PIEF_MASK_OFS, 8'h01);
        @(posedge pclk) timer_overflow <= 1'b1;
        @(posedge pclk) timer_overflow <= 1'b0;
        #1 chk1(tmr_flag, 1'b1);
        settle(1);
        chk1(irq, 1'b1);
        rd_chk(PIEF_REQ_OFS, 32'h20, 1'b0);
        wr(PIEF_STAT_OFS, 8'h01);
        settle(1);
        chk1(irq, 1'b0);
        chk1(tmr_flag, 1'b1);
        wr(PIEF_REQ_OFS, 8'h00);
        settle(1);
        chk1(tmr_flag, 1'b0);
    endtask
    // Summary follows the OR of both ports and ignores writes
    task t_pchg;
        @(posedge pclk) pa <= 6'h08;
        settle(2);
        chk1(pchg_flag, 1'b1);
        wr(PIEF_REQ_OFS, 8'h00);
        rd_chk(PIEF_REQ_OFS, 32'h10, 1'b0);
        pa <= 6'h00;
        pe <= 1'b1;
        settle(2);
        chk1(pchg_flag, 1'b1);
        @(posedge pclk) pe <= 1'b0;
        settle(2);
        chk1(pchg_flag, 1'b0);
    endtask
    // Only the selected pin sets the external flag
    task t_ext;
        wr(PIEF_PSEL_OFS, 8'h03);
        pins <= 8'h20;
        settle(8);
        chk1(ext_flag, 1'b0);
        @(posedge pclk) pins <= 8'h28;
        settle(8);
        chk1(ext_flag, 1'b1);
        @(posedge pclk) pins <= 8'h00;
        wr(PIEF_REQ_OFS, 8'h00);
        settle(1);
        chk1(ext_flag, 1'b0);
    endtask
    // Forwarding needs the source enable, peripheral and global enables
    task t_fwd;
        for (int i = 0; i < 3; i++) begin
            @(posedge pclk) {mem_f, osc_f, wave_f} <= 3'b100 >> i;
            wr(PIEF_CTRL_OFS, 8'hc0);
            settle(2);
            chk1(fwd, 1'b0);
            wr(PIEF_CTRL_OFS, 8'h40);
            wr(PIEF_EN6_OFS, (i == 0) ? 8'h20 : (i == 1) ? 8'h10 : 8'h01);
            settle(2);
            chk1(fwd, 1'b0);
            wr(PIEF_CTRL_OFS, 8'h80);
            settle(2);
            chk1(fwd, 1'b0);
            wr(PIEF_CTRL_OFS, 8'hc0);
            settle(2);
            chk1(fwd, 1'b1);
            @(posedge pclk) {mem_f, osc_f, wave_f} <= 3'b000;
            settle(2);
            chk1(fwd, 1'b0);
            wr(PIEF_EN6_OFS, 8'h00);
        end
    endtask
    // Status holds the pin, pin-change and forwarded rises of the earlier scenarios;
    // only the mask decides whether they reach the interrupt line
    task t_status;
        rd_chk(PIEF_STAT_OFS, 32'h0e, 1'b0);
        rd_chk(PIEF_CTRL_OFS, 32'hc0, 1'b0);
        rd_chk(PIEF_PSEL_OFS, 32'h03, 1'b0);
        wr(PIEF_MASK_OFS, 8'h0e);
        settle(1);
        chk1(irq, 1'b1);
        rd_chk(PIEF_MASK_OFS, 32'h0e, 1'b0);
        wr(PIEF_STAT_OFS, 8'h0e);
        settle(1);
        chk1(irq, 1'b0);
        rd_chk(PIEF_STAT_OFS, 32'h0, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        settle(4);
        chk1(tmr_flag | ext_flag | pchg_flag | irq, 1'b0);
        t_reset();
        t_enable();
        t_timer();
        t_pchg();
        t_ext();
        t_fwd();
        t_status();
        end_sim();
    end
endmodule // tb_pief_regs
